// ==== design/snc_decim_filter.sv ====
// Behaviour
// R01: Each channel has its own cubic sinc decimator, (1-z^-N)/(1-z^-1) cubed.
// R02: One modulator bit per modulator clock is taken, filtered and decimated.
// R03: One decimation field in the global setup register sets all channels.
// R04: The modulator clock is the device clock divided by 4 or by 16.
// R05: The response has notches at the data rate and its integer multiples.
// R06: After a step the results are settled only after three output periods.
// R07: After a start rising edge no result is given before settling is over.
// R08: Each channel setting register selects gain 1, 2, 3, 4, 6, 8 or 12.
// R09: Bits 7 to 6 of the drive electrode register pick pga_modulation_rate 8, 32 or 64 kSPS.
// R10: A bit of the second setup register raises the reference to 4 V.
// R11: Bit 6 of the lead status register selects 512 kHz or 2.048 MHz clock.
// R12: Results are 24-bit two's complement, MSB first, clipped at full scale.
// R13: Decimation code 000 gives 1024, halving per step to 16 at 110.
// R14: Accumulators are wide enough for ratio 1024; output cut to 24 bits.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module snc_decim_filter
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [snc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [snc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [snc_pkg::DATA_W-1:0] regRdData,
   input wire logic convStart,
   input wire logic modBit0,
   input wire logic modBit1,
   output logic modSampleTick,
   output logic [snc_pkg::RES_W-1:0] result0,
   output logic [snc_pkg::RES_W-1:0] result1,
   output logic resultValid,
   output logic [2:0] pgaGainCode0,
   output logic [2:0] pgaGainCode1,
   output logic [1:0] pgaModRate,
   output logic highRefSelect
);
   import snc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Log2 of the decimation ratio; the reserved code is held at ratio 16
   function automatic logic [3:0] ratioLog(input logic [2:0] code);
      logic [3:0] k;
      k = (code == DR_RESERVED) ? LOG2_MIN_RATIO :
          LOG2_MAX_RATIO - {1'b0, code};
      return k;
   endfunction

   // Scale a raw sinc3 word (full scale N^3) to a clipped 24-bit result
   function automatic logic [23:0] scaleResult(
      input logic signed [ACC_W-1:0] raw,
      input logic [3:0] k);
      logic [4:0] sh;
      logic signed [ACC_W-1:0] norm;
      logic signed [ACC_W-1:0] t;
      logic [23:0] res;
      sh = NORM_LOG2 - 5'({1'b0, k} * 5'h03);
      norm = raw <<< sh;
      t = norm >>> OUT_SHIFT;
      res = (t > $signed({8'h00, POS_FULL})) ? POS_FULL :
            (t < $signed({8'hFF, NEG_FULL})) ? NEG_FULL : t[23:0];
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and declarations
   logic [7:0] globalSetup_r;
   logic [7:0] secondSetup_r;
   logic [7:0] chSetting_r [NUM_CH];
   logic [7:0] driveSel_r;
   logic [7:0] leadStatus_r;
   logic [3:0] divCnt_r;
   logic [10:0] decimCnt_r;
   logic convStartPrev_r;
   snc_state_t state_r;
   snc_state_t state_nxt;
   logic [1:0] settleCnt_r;
   logic ready_r;
   logic signed [ACC_W-1:0] integ1_r [NUM_CH];
   logic signed [ACC_W-1:0] integ2_r [NUM_CH];
   logic signed [ACC_W-1:0] integ3_r [NUM_CH];
   logic signed [ACC_W-1:0] combDly1_r [NUM_CH];
   logic signed [ACC_W-1:0] combDly2_r [NUM_CH];
   logic signed [ACC_W-1:0] combDly3_r [NUM_CH];
   logic [RES_W-1:0] result_r [NUM_CH];
   logic resultValid_r;
   logic [7:0] rdData_r;

   ////////////////////////////////////////////////////////////////////////
   // Decode and selection
   wire logic wrGlobal = regWrStb && (regAddr == OFS_GLOBAL_SETUP);
   wire logic wrSecond = regWrStb && (regAddr == OFS_SECOND_SETUP);
   wire logic wrCh1 = regWrStb && (regAddr == OFS_CH1_SETTING);
   wire logic wrCh2 = regWrStb && (regAddr == OFS_CH2_SETTING);
   wire logic wrDrive = regWrStb && (regAddr == OFS_DRIVE_SEL);
   wire logic wrLead = regWrStb && (regAddr == OFS_LEAD_STATUS);
   wire logic rdStatus = regRdStb && (regAddr == OFS_FILT_STATUS);

   // Modulator rate: /16 for the fast external clock, else /4 [R04] [R11]
   wire logic [3:0] divLimit = leadStatus_r[CLKDIV_BIT] ? DIV_FAST : DIV_SLOW;
   wire logic modTick = (divCnt_r == divLimit);

   // One ratio field drives both channels, so rates always match [R03] [R13]
   wire logic [3:0] ratioK = ratioLog(globalSetup_r[DR_LSB +: 3]);
   wire logic [10:0] decimLast = 11'((12'h001 << ratioK) - 12'h001);
   wire logic decimEnd = modTick && (decimCnt_r == decimLast);

   // Restart on a start edge, any global setup write, or while start is low [R07]
   wire logic startRise = convStart && !convStartPrev_r;
   wire logic restart = startRise || wrGlobal || !convStart;
   wire logic settleDone = (settleCnt_r == SETTLE_PERIODS - 2'h1);
   wire logic emitNow = decimEnd && (state_r == ST_RUN ||
                        (state_r == ST_SETTLE && settleDone));

   // Modulator bits map to +1 / -1
   wire logic modBits [NUM_CH];
   assign modBits[0] = modBit0;
   assign modBits[1] = modBit1;

   // Front-end steering outputs [R08] [R09] [R10]
   assign pgaGainCode0 = chSetting_r[0][GAIN_LSB +: 3];
   assign pgaGainCode1 = chSetting_r[1][GAIN_LSB +: 3];
   assign pgaModRate = driveSel_r[PGA_MODULATION_RATE_LSB +: 2];
   assign highRefSelect = secondSetup_r[HIREF_BIT];
   assign modSampleTick = modTick;
   assign result0 = result_r[0];
   assign result1 = result_r[1];
   assign resultValid = resultValid_r;
   assign regRdData = rdData_r;

   ////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         globalSetup_r <= RST_GLOBAL_SETUP;
         secondSetup_r <= RST_OTHER;
         chSetting_r[0] <= RST_OTHER;
         chSetting_r[1] <= RST_OTHER;
         driveSel_r <= RST_OTHER;
         leadStatus_r <= RST_OTHER;
      end
      else
      begin
         if (wrGlobal)
            globalSetup_r <= regWrData;                       // [R03]
         if (wrSecond)
            secondSetup_r <= regWrData;                       // [R10]
         if (wrCh1)
            chSetting_r[0] <= regWrData;                      // [R08]
         if (wrCh2)
            chSetting_r[1] <= regWrData;                      // [R08]
         if (wrDrive)
            driveSel_r <= regWrData;                          // [R09]
         if (wrLead)
            leadStatus_r <= regWrData;                        // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Modulator clock divider and decimation counter
   // Decimation phase restarts with the filter so frames stay aligned
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         divCnt_r <= 4'h0;
         decimCnt_r <= 11'h000;
         convStartPrev_r <= 1'b0;
      end
      else
      begin
         convStartPrev_r <= convStart;
         divCnt_r <= modTick ? 4'h0 : divCnt_r + 4'h1;         // [R04]
         if (restart)
            decimCnt_r <= 11'h000;
         else if (decimEnd)
            decimCnt_r <= 11'h000;                            // [R02]
         else if (modTick)
            decimCnt_r <= decimCnt_r + 11'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settling state machine
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (convStart)
               state_nxt = ST_SETTLE;
         ST_SETTLE:
            if (decimEnd && settleDone)
               state_nxt = ST_RUN;                            // [R06] [R07]
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_IDLE;
      endcase
      if (restart)
         state_nxt = convStart ? ST_SETTLE : ST_IDLE;          // [R07]
   end

   // Count discarded periods: three are needed for the cubic kernel
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         settleCnt_r <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         if (restart)
            settleCnt_r <= 2'h0;
         else if (decimEnd && state_r == ST_SETTLE && !settleDone)
            settleCnt_r <= settleCnt_r + 2'h1;                // [R06]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Integrators run at the modulator rate. Wrap-around two's complement
   // is harmless: the combs cancel it as long as N^3 fits the width.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            integ1_r[c] <= '0;
            integ2_r[c] <= '0;
            integ3_r[c] <= '0;
         end
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (restart)
            begin
               integ1_r[c] <= '0;
               integ2_r[c] <= '0;
               integ3_r[c] <= '0;
            end
            else if (modTick)
            begin
               // Three cascaded accumulators, 32 bits for 1024^3 [R01] [R14]
               integ1_r[c] <= integ1_r[c] +
                              (modBits[c] ? 32'sh00000001 : -32'sh00000001);
               integ2_r[c] <= integ2_r[c] + integ1_r[c];
               integ3_r[c] <= integ3_r[c] + integ2_r[c];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Combs at the output rate; a delay of one output sample places the
   // notches at the data rate and every multiple of it
   logic signed [ACC_W-1:0] comb1 [NUM_CH];
   logic signed [ACC_W-1:0] comb2 [NUM_CH];
   logic signed [ACC_W-1:0] comb3 [NUM_CH];
   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         comb1[c] = integ3_r[c] - combDly1_r[c];              // [R05]
         comb2[c] = comb1[c] - combDly2_r[c];
         comb3[c] = comb2[c] - combDly3_r[c];
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            combDly1_r[c] <= '0;
            combDly2_r[c] <= '0;
            combDly3_r[c] <= '0;
            result_r[c] <= '0;
         end
         resultValid_r <= 1'b0;
      end
      else
      begin
         resultValid_r <= emitNow && !restart;                // [R07]
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (restart)
            begin
               combDly1_r[c] <= '0;
               combDly2_r[c] <= '0;
               combDly3_r[c] <= '0;
            end
            else if (decimEnd)
            begin
               combDly1_r[c] <= integ3_r[c];                  // [R01] [R02]
               combDly2_r[c] <= comb1[c];
               combDly3_r[c] <= comb2[c];
            end
            // Results only change when a settled word is ready
            if (emitNow && !restart)
               result_r[c] <= scaleResult(comb3[c], ratioK);  // [R12] [R14]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready flag: a new result wins over a status read in the same cycle
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ready_r <= 1'b0;
      else if (emitNow && !restart)
         ready_r <= 1'b1;
      else if (rdStatus)
         ready_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; result bytes sit MSB first at rising offsets [R12]
   logic [7:0] rdMux;
   always_comb
   begin
      rdMux = 8'h00;
      case (regAddr)
         OFS_GLOBAL_SETUP: rdMux = globalSetup_r;
         OFS_SECOND_SETUP: rdMux = secondSetup_r;
         OFS_CH1_SETTING: rdMux = chSetting_r[0];
         OFS_CH2_SETTING: rdMux = chSetting_r[1];
         OFS_DRIVE_SEL: rdMux = driveSel_r;
         OFS_LEAD_STATUS: rdMux = leadStatus_r;
         OFS_FILT_STATUS:
         begin
            rdMux[STAT_READY_BIT] = ready_r;
            rdMux[STAT_SETTLED_BIT] = (state_r == ST_RUN);
            rdMux[STAT_ACTIVE_BIT] = (state_r != ST_IDLE);
         end
         OFS_CH1_RES_HI: rdMux = result_r[0][23:16];
         OFS_CH1_RES_MID: rdMux = result_r[0][15:8];
         OFS_CH1_RES_LO: rdMux = result_r[0][7:0];
         OFS_CH2_RES_HI: rdMux = result_r[1][23:16];
         OFS_CH2_RES_MID: rdMux = result_r[1][15:8];
         OFS_CH2_RES_LO: rdMux = result_r[1][7:0];
         default: rdMux = 8'h00;                              // Unmapped
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         rdData_r <= 8'h00;
      else
         rdData_r <= regRdStb ? rdMux : 8'h00;
   end

endmodule

`default_nettype wire

// ==== design/snc_pkg.sv ====
package snc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus and channel geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int NUM_CH = 2;
   localparam int RES_W = 24;
   localparam int ACC_W = 32;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [4:0] OFS_GLOBAL_SETUP = 5'h01;
   localparam logic [4:0] OFS_SECOND_SETUP = 5'h02;
   localparam logic [4:0] OFS_CH1_SETTING = 5'h04;
   localparam logic [4:0] OFS_CH2_SETTING = 5'h05;
   localparam logic [4:0] OFS_DRIVE_SEL = 5'h06;
   localparam logic [4:0] OFS_LEAD_STATUS = 5'h08;
   localparam logic [4:0] OFS_FILT_STATUS = 5'h10;
   localparam logic [4:0] OFS_CH1_RES_HI = 5'h11;
   localparam logic [4:0] OFS_CH1_RES_MID = 5'h12;
   localparam logic [4:0] OFS_CH1_RES_LO = 5'h13;
   localparam logic [4:0] OFS_CH2_RES_HI = 5'h14;
   localparam logic [4:0] OFS_CH2_RES_MID = 5'h15;
   localparam logic [4:0] OFS_CH2_RES_LO = 5'h16;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int DR_LSB = 0;
   localparam int GAIN_LSB = 4;
   localparam int PGA_MODULATION_RATE_LSB = 6;
   localparam int HIREF_BIT = 4;
   localparam int CLKDIV_BIT = 6;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_SETTLED_BIT = 1;
   localparam int STAT_ACTIVE_BIT = 2;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_GLOBAL_SETUP = 8'h02;
   localparam logic [7:0] RST_OTHER = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Filter and timing counts
   localparam logic [2:0] DR_RESERVED = 3'h7;
   localparam logic [3:0] LOG2_MAX_RATIO = 4'hA;
   localparam logic [3:0] LOG2_MIN_RATIO = 4'h4;
   localparam logic [3:0] DIV_SLOW = 4'h3;     // Device clock / 4
   localparam logic [3:0] DIV_FAST = 4'hF;     // Device clock / 16
   localparam logic [1:0] SETTLE_PERIODS = 2'h3;
   localparam logic [4:0] NORM_LOG2 = 5'h1E;   // Full scale 2^30
   localparam int OUT_SHIFT = 7;               // 2^30 down to 2^23
   localparam logic [23:0] POS_FULL = 24'h7FFFFF;
   localparam logic [23:0] NEG_FULL = 24'h800000;

   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} snc_state_t;

endpackage

// ==== verif/snc_decim_filter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module snc_decim_filter_monitor
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [snc_pkg::ADDR_W-1:0] regAddr,
   input wire logic [snc_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrStb,
   input wire logic convStart,
   input wire logic modSampleTick,
   input wire logic [snc_pkg::RES_W-1:0] result0,
   input wire logic [snc_pkg::RES_W-1:0] result1,
   input wire logic resultValid,
   input wire logic [2:0] pgaGainCode0,
   input wire logic [2:0] pgaGainCode1,
   input wire logic [1:0] pgaModRate,
   input wire logic highRefSelect
);
   import snc_pkg::*;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // Building blocks
   sequence sWr(logic [4:0] a);
      regWrStb && regAddr == a;
   endsequence
   sequence sNoValid;
      !resultValid [*8];
   endsequence

   ////////////////////////////////////////////////////////////////////////
   // Sampling ticks come at least 4 and at most 16 cycles apart
   AST_TICK_MIN: assert property (
      modSampleTick |=> !modSampleTick [*3])
      else $error("sampling ticks closer than four cycles");
   AST_TICK_MAX: assert property (
      modSampleTick |-> ##[1:16] modSampleTick)
      else $error("sampling tick missing");

   ////////////////////////////////////////////////////////////////////////
   // Results follow a tick and are spaced by at least nine cycles
   AST_VALID_TICK: assert property (
      resultValid |-> $past(modSampleTick))
      else $error("result not one cycle after a tick");
   AST_VALID_GAP: assert property (
      resultValid |=> sNoValid)
      else $error("results closer than one period");
   AST_START_WAIT: assert property (
      $rose(convStart) |-> sNoValid)
      else $error("result right after start");
   AST_STOPPED: assert property (
      !convStart && !$past(convStart) |-> !resultValid)
      else $error("result while stopped");
   // Results may only move together with the valid pulse
   AST_RES_HOLD: assert property (
      !resultValid |-> $stable(result0) && $stable(result1))
      else $error("result changed without valid");

   ////////////////////////////////////////////////////////////////////////
   // Setting registers drive the front end right after the write
   AST_GAIN0: assert property (
      sWr(OFS_CH1_SETTING) |=> pgaGainCode0 == $past(regWrData[6:4]))
      else $error("gain code 0 not taken");
   AST_GAIN1: assert property (
      sWr(OFS_CH2_SETTING) |=> pgaGainCode1 == $past(regWrData[6:4]))
      else $error("gain code 1 not taken");
   AST_PGA_MODULATION_RATE: assert property (
      sWr(OFS_DRIVE_SEL) |=> pgaModRate == $past(regWrData[7:6]))
      else $error("pga_modulation_rate rate not taken");
   AST_HIREF: assert property (
      sWr(OFS_SECOND_SETUP) |=> highRefSelect == $past(regWrData[4]))
      else $error("reference select not taken");
endmodule

bind snc_decim_filter snc_decim_filter_monitor u_mon
(
   .ref_clk,
   .rst,
   .regAddr,
   .regWrData,
   .regWrStb,
   .convStart,
   .modSampleTick,
   .result0,
   .result1,
   .resultValid,
   .pgaGainCode0,
   .pgaGainCode1,
   .pgaModRate,
   .highRefSelect
);

`default_nettype wire

// ==== verif/snc_mod_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module snc_mod_model
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic modSampleTick,
   input wire logic level0,
   input wire logic level1,
   output logic modBit0,
   output logic modBit1
);
   ////////////////////////////////////////////////////////////////////////
   // New bit just after each tick, so the filter sees a full-period bit
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         {modBit0, modBit1} <= 2'b00;
      else if (modSampleTick)
         {modBit0, modBit1} <= {level0, level1};
   end
endmodule

`default_nettype wire

// ==== verif/snc_decim_filter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module snc_decim_filter_tb;
   import snc_pkg::*;

   logic ref_clk, rst, regWrStb, regRdStb, convStart, level0, level1;
   logic modBit0, modBit1, modSampleTick, resultValid, highRefSelect;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWrData, regRdData;
   logic [RES_W-1:0] result0, result1;
   logic [2:0] pgaGainCode0, pgaGainCode1;
   logic [1:0] pgaModRate;
   int err_total = 0;
   int samples_checked = 0;
   int i;
   localparam logic [4:0] ZREGS [6] = '{OFS_SECOND_SETUP, OFS_CH1_SETTING,
      OFS_CH2_SETTING, OFS_DRIVE_SEL, OFS_LEAD_STATUS, 5'h1F};

   snc_decim_filter u_dut (.ref_clk, .rst, .regAddr, .regWrData, .regWrStb,
      .regRdStb, .regRdData, .convStart, .modBit0, .modBit1, .modSampleTick,
      .result0, .result1, .resultValid, .pgaGainCode0, .pgaGainCode1,
      .pgaModRate, .highRefSelect);
   snc_mod_model u_mod (.ref_clk, .rst, .modSampleTick, .level0, .level1,
      .modBit0, .modBit1);

   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic check(input string nm, input logic [23:0] got,
      input logic [23:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [4:0] a, input logic [7:0] m,
      input logic [7:0] e);
      @(posedge ref_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1;
      check("regRdData", 24'(regRdData & m), 24'(e));
   endtask

   task automatic gap(input int e);
      int n;
      n = 0;
      @(posedge ref_clk iff modSampleTick);
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (!modSampleTick && n < 40);
      check("tick gap", 24'(n), 24'(e));
   endtask

   // Start synced to a tick, so the tick count to each result is exact
   task automatic conv(input logic [2:0] c, input logic [23:0] e0,
      input logic [23:0] e1);
      int n, g, k, nTick;
      logic [47:0] both;
      nTick = (c == 3'h7) ? 16 : 1024 >> c;
      both = {e0, e1};
      convStart <= 1'b0;
      wr(OFS_GLOBAL_SETUP, {5'h00, c});
      @(posedge ref_clk iff modSampleTick);
      convStart <= 1'b1;
      for (k = 0; k < 2; k++)
      begin
         n = 0;
         g = 0;
         do
         begin
            @(posedge ref_clk);
            g++;
            if (modSampleTick)
               n++;
         end
         while (!resultValid && g < 70000);
         check("ticks", 24'(n), 24'(k ? nTick : 3 * nTick));
      end
      #1;
      check("result0", result0, e0);
      check("result1", result1, e1);
      // Ready, settled and active after a result; ready clears on read
      rdc(OFS_FILT_STATUS, 8'h07, 8'h07);
      rdc(OFS_FILT_STATUS, 8'h07, 8'h06);
      wr(OFS_CH1_RES_HI, 8'h00);
      for (k = 0; k < 6; k++)
         rdc(OFS_CH1_RES_HI + 5'(k), 8'hFF, both[47-8*k -: 8]);
   endtask

   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Clock and watchdog; the run needs about 35k cycles
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      #400000;
      err_total++;
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst = 1'b1;
      regAddr = '0;
      regWrData = '0;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      convStart = 1'b0;
      level0 = 1'b1;
      level1 = 1'b0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rdc(OFS_GLOBAL_SETUP, 8'hFF, RST_GLOBAL_SETUP);
      foreach (ZREGS[i])
         rdc(ZREGS[i], 8'hFF, RST_OTHER);
      for (i = 0; i < 7; i++)
      begin
         wr(OFS_CH1_SETTING, 8'(i << GAIN_LSB));
         wr(OFS_CH2_SETTING, 8'((6 - i) << GAIN_LSB));
         #1;
         check("gain0", 24'(pgaGainCode0), 24'(i));
         check("gain1", 24'(pgaGainCode1), 24'(6 - i));
      end
      rdc(OFS_CH1_SETTING, 8'hFF, 8'h60);
      for (i = 0; i < 3; i++)
      begin
         wr(OFS_DRIVE_SEL, 8'(i << PGA_MODULATION_RATE_LSB));
         #1;
         check("pga_modulation_rate", 24'(pgaModRate), 24'(i));
      end
      wr(OFS_SECOND_SETUP, 8'h10);
      #1;
      check("high ref", 24'(highRefSelect), 24'h000001);
      rdc(OFS_SECOND_SETUP, 8'hFF, 8'h10);
      gap(4);
      // Every ratio code, both channels at opposite full scale
      for (i = 0; i < 8; i++)
         conv(3'(i), POS_FULL, NEG_FULL);
      wr(OFS_LEAD_STATUS, 8'h40);
      rdc(OFS_LEAD_STATUS, 8'hFF, 8'h40);
      gap(16);
      level0 <= 1'b0;
      level1 <= 1'b1;
      conv(3'h6, NEG_FULL, POS_FULL);
      convStart <= 1'b0;
      repeat (300) @(posedge ref_clk);
      rdc(OFS_FILT_STATUS, 8'h07, 8'h00);
      close_out();
   end
endmodule

`default_nettype wire
